// file: hdl/swe_sleep_wake_ctrl.sv
// sleep/wake run control with per-block exception masks on AXI4-Lite
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "swe_cfg.svh"
// Contract
// - light sleep gates clocks except excepted blocks
// - deep sleep removes core, cache, block power
// - magic packet, timer or interrupt wakes
// - set mask bit keeps block clocked, powered
// - four bit 12 keeps RAM, protection powered
// - four bit 10 keeps debug blocks powered
// - four bit 9 keeps GPIO controllers powered
// - four bit 0 keeps DDR powered
module swe_sleep_wake_ctrl
  import swe_pkg::*;
(
  // clock and reset
  input  wire logic          clk_sys,
  input  wire logic          rst,
  // axi4-lite write address
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  // axi4-lite write response
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  // wake pins: magic packet, timer, interrupt
  input  wire logic [2:0]    wakePin,
  // block clock and power enables
  output logic [223:0]       ipClockOn,
  output logic [223:0]       ipPowerOn,
  output logic               coreClockOn,
  output logic               corePowerOn,
  output logic [1:0]         sleepState
);
  // ****************************************************************
  // registers and wires
  // ****************************************************************
  swe_word_t       excMask_reg [0:`SWE_EXC_COUNT-1];
  swe_state_e      state_reg;
  swe_state_e      state_next;
  logic [2:0]      cause_reg;
  logic [2:0]      cause_next;
  logic [2:0]      wakeLevel;
  logic [7:0]      awAddr_reg;
  logic [31:0]     wData_reg;
  logic [3:0]      wStrb_reg;
  logic            awHave_reg;
  logic            wHave_reg;
  logic            awFire;
  logic            wFire;
  logic            arFire;
  logic            doWrite;
  logic [7:0]      wrAddr;
  logic [31:0]     wrData;
  logic [3:0]      wrStrb;
  logic [31:0]     wrMerged;
  logic            wrExc;
  logic [2:0]      wrIdx;
  logic            wrCtrl;
  logic            wrCause;
  logic            wrOk;
  logic            rdExc;
  logic [2:0]      rdIdx;
  logic            rdOk;
  logic [31:0]     rdWord;
  logic            reqLight;
  logic            reqDeep;
  logic            wakeAny;
  logic [223:0]    maskFlat;
  logic [223:0]    clock_next;
  logic [223:0]    power_next;

  // ****************************************************************
  // helper functions
  // ****************************************************************
  function automatic logic isExc(input logic [7:0] addr);
    isExc = (addr >= `SWE_EXC_BASE) && (addr <= `SWE_EXC_LAST) && (addr[1:0] == 2'h0);
  endfunction : isExc

  function automatic logic [2:0] excIdx(input logic [7:0] addr);
    excIdx = addr[4:2];
  endfunction : excIdx

  function automatic logic [31:0] strbMerge(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = oldV;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = newV[b*8 +: 8];
      end
    end
    strbMerge = res;
  endfunction : strbMerge

  // ****************************************************************
  // wake pin synchroniser
  // ****************************************************************
  swe_pin_sync #(
    .WIDTH (`SWE_WAKE_W)
  ) u_wake_sync (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .pinIn    (wakePin),
    .levelOut (wakeLevel)
  );

  // ****************************************************************
  // bus decode
  // ****************************************************************
  assign awFire   = s_axi_awvalid & s_axi_awready;
  assign wFire    = s_axi_wvalid & s_axi_wready;
  assign arFire   = s_axi_arvalid & s_axi_arready;
  assign wrAddr   = awHave_reg ? awAddr_reg : s_axi_awaddr;
  assign wrData   = wHave_reg ? wData_reg : s_axi_wdata;
  assign wrStrb   = wHave_reg ? wStrb_reg : s_axi_wstrb;
  assign doWrite  = (awHave_reg | awFire) & (wHave_reg | wFire) & ~s_axi_bvalid;
  assign wrExc    = isExc(wrAddr);
  assign wrIdx    = excIdx(wrAddr);
  assign wrCtrl   = (wrAddr == `SWE_CTRL_OFF);
  assign wrCause  = (wrAddr == `SWE_CAUSE_OFF);
  assign wrOk     = wrExc | wrCtrl | wrCause | (wrAddr == `SWE_STATUS_OFF);
  assign wrMerged = strbMerge(excMask_reg[wrIdx], wrData, wrStrb);
  assign reqLight = doWrite & wrCtrl & wrStrb[0] & wrData[`SWE_CTRL_LIGHT];
  assign reqDeep  = doWrite & wrCtrl & wrStrb[0] & wrData[`SWE_CTRL_DEEP];
  assign rdExc    = isExc(s_axi_araddr);
  assign rdIdx    = excIdx(s_axi_araddr);
  assign rdOk     = rdExc | (s_axi_araddr == `SWE_CTRL_OFF)
                  | (s_axi_araddr == `SWE_STATUS_OFF) | (s_axi_araddr == `SWE_CAUSE_OFF);
  assign rdWord   = rdExc ? excMask_reg[rdIdx]
                  : (s_axi_araddr == `SWE_STATUS_OFF) ? {30'h0, state_reg}
                  : (s_axi_araddr == `SWE_CAUSE_OFF) ? {29'h0, cause_reg}
                  : 32'h00000000;

  // ****************************************************************
  // sleep state machine
  // ****************************************************************
  assign wakeAny = |wakeLevel;

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      SWE_RUN: begin
        if (reqDeep) begin
          state_next = SWE_DEEP;
        end else if (reqLight) begin
          state_next = SWE_LIGHT;
        end
      end
      SWE_LIGHT, SWE_DEEP: begin
        if (wakeAny) begin
          state_next = SWE_WAKE;
        end
      end
      SWE_WAKE: begin
        state_next = SWE_RUN;
      end
    endcase
  end

  // sticky wake cause, set beats a write-one clear
  assign cause_next = ((state_reg == SWE_LIGHT || state_reg == SWE_DEEP) ? wakeLevel : 3'h0)
                    | (cause_reg & ~((doWrite & wrCause & wrStrb[0]) ? wrData[2:0] : 3'h0));

  // ****************************************************************
  // clock and power enables
  // ****************************************************************
  always_comb begin
    for (int r = 0; r < `SWE_EXC_COUNT; r++) begin
      maskFlat[r*32 +: 32] = excMask_reg[r];
    end
  end

  // mask bits keep blocks alive while asleep; wake and run enable all
  assign clock_next = (state_next == SWE_LIGHT || state_next == SWE_DEEP)
                    ? maskFlat : {224{1'b1}};
  assign power_next = (state_next == SWE_DEEP)
                    ? maskFlat : {224{1'b1}};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_reg   <= SWE_RUN;
      cause_reg   <= 3'h0;
      ipClockOn   <= {224{1'b1}};
      ipPowerOn   <= {224{1'b1}};
      coreClockOn <= 1'b1;
      corePowerOn <= 1'b1;
      sleepState  <= 2'h0;
    end else begin
      state_reg   <= state_next;
      cause_reg   <= cause_next;
      ipClockOn   <= clock_next;
      ipPowerOn   <= power_next;
      coreClockOn <= (state_next == SWE_RUN) || (state_next == SWE_WAKE);
      corePowerOn <= (state_next != SWE_DEEP);
      sleepState  <= state_next;
    end
  end

  // ****************************************************************
  // exception mask registers
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int r = 0; r < `SWE_EXC_COUNT; r++) begin
        excMask_reg[r] <= `SWE_EXC_RESET;
      end
    end else if (doWrite && wrExc) begin
      if (wrIdx == `SWE_EXC_FOUR_IDX) begin
        excMask_reg[wrIdx] <= wrMerged & `SWE_EXC_FOUR_WMSK;
      end else begin
        excMask_reg[wrIdx] <= wrMerged;
      end
    end
  end

  // ****************************************************************
  // axi4-lite write channels
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      awHave_reg    <= 1'b0;
      wHave_reg     <= 1'b0;
      awAddr_reg    <= 8'h00;
      wData_reg     <= 32'h00000000;
      wStrb_reg     <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SWE_RESP_OKAY;
    end else begin
      if (doWrite) begin
        awHave_reg    <= 1'b0;
        wHave_reg     <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
        s_axi_bvalid  <= 1'b1;
        s_axi_bresp   <= wrOk ? `SWE_RESP_OKAY : `SWE_RESP_SLVERR;
      end else begin
        if (awFire) begin
          awHave_reg    <= 1'b1;
          awAddr_reg    <= s_axi_awaddr;
          s_axi_awready <= 1'b0;
        end else if (!awHave_reg && !s_axi_bvalid) begin
          s_axi_awready <= 1'b1;
        end
        if (wFire) begin
          wHave_reg    <= 1'b1;
          wData_reg    <= s_axi_wdata;
          wStrb_reg    <= s_axi_wstrb;
          s_axi_wready <= 1'b0;
        end else if (!wHave_reg && !s_axi_bvalid) begin
          s_axi_wready <= 1'b1;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ****************************************************************
  // axi4-lite read channels
  // ****************************************************************
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SWE_RESP_OKAY;
    end else begin
      if (arFire) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdWord;
        s_axi_rresp   <= rdOk ? `SWE_RESP_OKAY : `SWE_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule : swe_sleep_wake_ctrl

// file: hdl/swe_cfg.svh
// offsets, field positions, reset values and counts of the sleep/wake controller
`ifndef SWE_CFG_SVH
`define SWE_CFG_SVH
`define SWE_ADDR_W        8
`define SWE_EXC_COUNT     7
`define SWE_EXC_BASE      8'h00
`define SWE_EXC_LAST      8'h18
`define SWE_CTRL_OFF      8'h20
`define SWE_STATUS_OFF    8'h24
`define SWE_CAUSE_OFF     8'h28
`define SWE_EXC_FOUR_IDX  3'h4
`define SWE_EXC_FOUR_WMSK 32'h00001601
`define SWE_EXC_RESET     32'h00000000
`define SWE_CTRL_LIGHT    0
`define SWE_CTRL_DEEP     1
`define SWE_WAKE_MAGIC    0
`define SWE_WAKE_TIMER    1
`define SWE_WAKE_IRQ      2
`define SWE_WAKE_W        3
`define SWE_RESP_OKAY     2'h0
`define SWE_RESP_SLVERR   2'h2
`endif

// file: hdl/swe_pkg.sv
// types of the sleep/wake controller
package swe_pkg;
  typedef enum logic [1:0] {
    SWE_RUN   = 2'h0,
    SWE_LIGHT = 2'h1,
    SWE_DEEP  = 2'h3,
    SWE_WAKE  = 2'h2
  } swe_state_e;
  typedef logic [31:0] swe_word_t;
endpackage : swe_pkg

// file: hdl/swe_pin_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module swe_pin_sync
  import swe_pkg::*;
#(
  parameter int WIDTH = 3
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // pins and filtered levels
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] levelOut
);
  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;
  logic [WIDTH-1:0] agree;
  logic [WIDTH-1:0] level_next;

  assign agree      = ~(stage2_reg ^ stage3_reg);
  assign level_next = (agree & stage3_reg) | (~agree & levelOut);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
      levelOut   <= '0;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
      levelOut   <= level_next;
    end
  end
endmodule : swe_pin_sync

// file: sim/swe_wake_src_model.sv
// wake-source model: peripheral blocks raising wake levels
`timescale 1ns/100ps
module swe_wake_src_model #(
  parameter int HOLD = 10
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // requests and wake levels
  input  wire logic [2:0] fire,
  output logic      [2:0] wakePin
);
  int cnt [3];
  // ********
  // level held for HOLD cycles, then low
  // ********
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int b = 0; b < 3; b++) begin
        cnt[b] <= 0;
      end
    end else begin
      for (int b = 0; b < 3; b++) begin
        if (fire[b]) begin
          cnt[b] <= HOLD;
        end else if (cnt[b] > 0) begin
          cnt[b] <= cnt[b] - 1;
        end
      end
    end
  end
  always_comb begin
    for (int b = 0; b < 3; b++)
      wakePin[b] = cnt[b] > 0;
  end
endmodule : swe_wake_src_model

// file: sim/swe_sleep_wake_ctrl_monitor.sv
// checker of sleep, wake and enable relations at the controller ports
`timescale 1ns/100ps
module swe_sleep_wake_ctrl_monitor (
  // clock and reset
  input wire logic         clk_sys,
  input wire logic         rst,
  // wake pins and enables
  input wire logic [2:0]   wakePin,
  input wire logic [223:0] ipClockOn,
  input wire logic [223:0] ipPowerOn,
  input wire logic         coreClockOn,
  input wire logic         corePowerOn,
  input wire logic [1:0]   sleepState
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire logic asleep;
  assign asleep = sleepState == 2'h1 || sleepState == 2'h3;
  // ********
  // assertions
  // ********
  a_light_core: assert property (sleepState == 2'h1 |-> !coreClockOn && corePowerOn)
    else $error("light core enables wrong");
  a_light_power: assert property (sleepState == 2'h1 |-> &ipPowerOn)
    else $error("light block power wrong");
  a_deep_core: assert property (sleepState == 2'h3 |-> !coreClockOn && !corePowerOn)
    else $error("deep core enables wrong");
  a_deep_match: assert property (sleepState == 2'h3 |-> ipPowerOn == ipClockOn)
    else $error("deep power differs from clock");
  a_wake_exit: assert property (asleep && |wakePin |-> ##[1:10] sleepState == 2'h2)
    else $error("no wake after pin");
  a_wake_brief: assert property (sleepState == 2'h2 |=> sleepState == 2'h0)
    else $error("wake not one cycle");
  a_wake_on: assert property (sleepState == 2'h2 |-> &ipClockOn && &ipPowerOn
    && coreClockOn && corePowerOn) else $error("wake enables not all on");
  a_four_reserved: assert property (asleep |-> (ipClockOn[159:128] & 32'hFFFF_E9FE) == 32'h0)
    else $error("reserved mask bit set");
  a_run_on: assert property (sleepState == 2'h0 |-> &ipClockOn && &ipPowerOn
    && coreClockOn && corePowerOn) else $error("run enables not all on");
  c_light: cover property (sleepState == 2'h1);
  c_deep: cover property (sleepState == 2'h3);
  c_wake: cover property (sleepState == 2'h2);
endmodule : swe_sleep_wake_ctrl_monitor
bind swe_sleep_wake_ctrl swe_sleep_wake_ctrl_monitor i_mon (
  .clk_sys(clk_sys), .rst(rst), .wakePin(wakePin), .ipClockOn(ipClockOn),
  .ipPowerOn(ipPowerOn), .coreClockOn(coreClockOn), .corePowerOn(corePowerOn),
  .sleepState(sleepState));

// file: sim/test_swe_sleep_wake_ctrl.sv
// self-checking bench of the sleep/wake controller
`timescale 1ns/100ps
module test_swe_sleep_wake_ctrl;
  logic         clk_sys = 1'b0;
  logic         rst = 1'b1;
  logic [7:0]   s_axi_awaddr = 8'h00;
  logic [7:0]   s_axi_araddr = 8'h00;
  logic [31:0]  s_axi_wdata = 32'h0;
  logic [3:0]   s_axi_wstrb = 4'hF;
  logic         s_axi_awvalid = 1'b0;
  logic         s_axi_wvalid = 1'b0;
  logic         s_axi_bready = 1'b0;
  logic         s_axi_arvalid = 1'b0;
  logic         s_axi_rready = 1'b0;
  logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]   s_axi_bresp, s_axi_rresp, sleepState;
  logic [31:0]  s_axi_rdata;
  logic [2:0]   wakePin;
  logic [2:0]   fire = 3'h0;
  logic [223:0] ipClockOn, ipPowerOn;
  logic         coreClockOn, corePowerOn;
  int           mismatches = 0;
  int           check_count = 0;
  int           cycles = 0;
  always #50 clk_sys = ~clk_sys;
  swe_sleep_wake_ctrl i_dut (
    .clk_sys(clk_sys), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .wakePin(wakePin), .ipClockOn(ipClockOn), .ipPowerOn(ipPowerOn),
    .coreClockOn(coreClockOn), .corePowerOn(corePowerOn), .sleepState(sleepState));
  swe_wake_src_model i_src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .wakePin(wakePin));
  // ********
  // tasks
  // ********
  task automatic print_verdict();
    if (mismatches == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic tA, tW;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge clk_sys);
      tA = s_axi_awready && s_axi_awvalid;
      tW = s_axi_wready && s_axi_wvalid;
      @(posedge clk_sys);
      if (tA) s_axi_awvalid <= 1'b0;
      if (tW) s_axi_wvalid <= 1'b0;
    end while (s_axi_awvalid && !tA || s_axi_wvalid && !tW);
    do @(negedge clk_sys); while (!s_axi_bvalid);
    r = s_axi_bresp;
    @(posedge clk_sys);
    s_axi_bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk_sys); while (!s_axi_arready);
    @(posedge clk_sys);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_sys); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge clk_sys);
    s_axi_rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_read
  task automatic t_regs();
    logic [31:0] d, v;
    logic [1:0]  r;
    for (int i = 0; i < 7; i++) begin
      v = 32'hFFFF_FFF0 | i;
      axi_read(8'(4 * i), d, r);
      chk(d, 32'h0);
      axi_write(8'(4 * i), v, r);
      chk(32'(r), 32'h0);
      axi_read(8'(4 * i), d, r);
      chk(d, (i == 4) ? v & 32'h0000_1601 : v);
      axi_write(8'(4 * i), 32'h0, r);
    end
    s_axi_wstrb <= 4'h2;
    axi_write(8'h00, 32'hAABB_CCDD, r);
    s_axi_wstrb <= 4'hF;
    axi_read(8'h00, d, r);
    chk(d, 32'h0000_CC00);
    axi_write(8'h00, 32'h0, r);
    axi_write(8'h40, 32'h1, r);
    chk(32'(r), 32'h2);
    axi_read(8'h40, d, r);
    chk({d[29:0], r}, 32'h2);
  endtask : t_regs
  task automatic t_sleep(input logic [31:0] ctrl, input int src, input logic [31:0] m0,
                         input logic [31:0] m4, input logic [1:0] st);
    logic [31:0] d;
    logic [1:0]  r;
    axi_write(8'h00, m0, r);
    axi_write(8'h10, m4, r);
    axi_write(8'h28, 32'h7, r);
    axi_write(8'h20, ctrl, r);
    chk(32'(r), 32'h0);
    @(negedge clk_sys);
    chk(32'(sleepState), 32'(st));
    chk(ipClockOn[31:0], m0);
    chk(ipClockOn[159:128], m4 & 32'h1601);
    chk(ipPowerOn[159:128], st == 2'h3 ? m4 & 32'h1601 : 32'hFFFF_FFFF);
    chk(32'({coreClockOn, corePowerOn}), st == 2'h3 ? 32'h0 : 32'h1);
    @(posedge clk_sys);
    axi_read(8'h24, d, r);
    chk(d, 32'(st));
    fire[src] <= 1'b1;
    @(posedge clk_sys);
    fire <= 3'h0;
    while (sleepState !== 2'h0) @(negedge clk_sys);
    chk(32'(&ipClockOn && &ipPowerOn && coreClockOn && corePowerOn), 32'h1);
    @(posedge clk_sys);
    axi_read(8'h28, d, r);
    chk(d, 32'h1 << src);
    repeat (12) @(posedge clk_sys);
  endtask : t_sleep
  // ********
  // sequence and timeout
  // ********
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    t_regs();
    t_sleep(32'h1, 0, 32'h1, 32'h0200, 2'h1);
    t_sleep(32'h3, 1, 32'h18, 32'h1601, 2'h3);
    t_sleep(32'h1, 2, 32'h0, 32'h0200, 2'h1);
    print_verdict();
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end
endmodule : test_swe_sleep_wake_ctrl
